// ### inc/iok_defines.svh
// Register indices, field positions and reset values of the I/O port and key strobe block.
// Assumes a classic Wishbone slave where byte address = 4 * register index.
`ifndef IOK_DEFINES_SVH
`define IOK_DEFINES_SVH

// ****************************************
// Register indices
// ****************************************
`define IOK_IDX_PA_LATCH 12'h0D8
`define IOK_IDX_PB_LATCH 12'h0D9
`define IOK_IDX_PB_FSEL 12'h0D5
`define IOK_IDX_PA_DIR 12'h240
`define IOK_IDX_PA_CFG 12'h241
`define IOK_IDX_PB_DIR 12'h244
`define IOK_IDX_PB_CFG 12'h245
`define IOK_IDX_STROBE_CONTROL 12'h252
`define IOK_IDX_STROBE_COMMON_INDEX 12'h253
`define IOK_IDX_KEY_LATCH 12'h254
`define IOK_IDX_EVENT 12'h2F0

// ****************************************
// Field positions
// ****************************************
`define IOK_CFG_PULL 0
`define IOK_CFG_NMOS 1
`define IOK_CFG_WEAK 2
`define IOK_CFG_STB 3
`define IOK_CFG_UPPER 4
`define IOK_STB_BLANK 0
`define IOK_STB_CLEAR 1
`define IOK_EV_STATUS 0
`define IOK_EV_IRQ_EN 1
`define IOK_EV_HALT_EN 2

// ****************************************
// Reset values and synchroniser settle count
// ****************************************
`define IOK_RST_BYTE 8'h00
`define IOK_RST_COM 3'h0
`define IOK_SYNC_SETTLE 2'h3

`endif

// ### inc/iok_pkg.sv
// Types shared by the I/O port and key strobe block.
// Assumes pad cells resolve out, oe and pull controls into a wire level.
package iok_pkg;

   // ****************************************
   // Pad control bundle
   // ****************************************
   typedef struct packed
   {
      logic [5:0] out;
      logic [5:0] oe;
      logic [5:0] pull_en;
      logic [5:0] pull_weak;
   } iok_pad_a_type;

   typedef struct packed
   {
      logic [1:0] out;
      logic [1:0] oe;
      logic [1:0] pull_en;
      logic [1:0] pull_weak;
   } iok_pad_b_type;

   // ****************************************
   // Display scanner status
   // ****************************************
   typedef struct packed
   {
      logic display_on;
      logic strobe_window;
      logic [2:0] common_line;
   } iok_scan_type;

endpackage : iok_pkg

// ### logic/iok_ports.sv
// Six-pin and two-pin general ports with pin-change event and key strobe latch.
// Assumes a classic Wishbone master, pads resolved outside, and a display scanner on clk.
`include "iok_defines.svh"

module iok_ports
   import iok_pkg::*;
#(
   parameter int SEG_W = 32
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [5:0] port_a_in,
   input wire logic [1:0] port_b_in,
   output iok_pad_a_type pads_a,
   output iok_pad_b_type pads_b,
   input wire iok_scan_type scan,
   input wire logic [SEG_W-1:0] segment_ram,
   output logic [SEG_W-1:0] segment_out,
   input wire logic timer_a_carrier,
   input wire logic timer_b_carrier,
   output logic timer_a_clk_in,
   output logic timer_b_clk_in,
   output logic port_irq,
   output logic halt_release
);

   // ****************************************
   // Registers and synchronisers
   // ****************************************
   logic [7:0] pa_latch_r;
   logic [7:0] pb_latch_r;
   logic [7:0] pa_dir_r;
   logic [7:0] pa_cfg_r;
   logic [7:0] pb_dir_r;
   logic [7:0] pb_cfg_r;
   logic [1:0] pb_fsel_r;
   logic seg_blank_r;
   logic [2:0] com_r;
   logic [7:0] key_r;
   logic armed_r;
   logic ev_r;
   logic irq_en_r;
   logic halt_en_r;
   logic ack_r;
   logic [31:0] dat_r;
   logic [5:0] a_s1_r;
   logic [5:0] a_s2_r;
   logic [5:0] a_s3_r;
   logic [1:0] b_s1_r;
   logic [1:0] b_s2_r;
   logic [1:0] settle_r;
   logic [SEG_W-1:0] seg_r;
   logic [11:0] idx;
   logic req;
   logic wr;
   logic clr;
   logic [7:0] hit;
   logic ev_set;
   logic [7:0] rd_a;
   logic [7:0] rd_b;

   // Upper pins 4 and 5 use config nibble 7:4, pins 0 to 3 use 3:0.
   function automatic logic [3:0] group_cfg(input logic [7:0] cfg, input int pin);
      group_cfg = (pin >= 4) ? cfg[7:4] : cfg[3:0];
   endfunction : group_cfg

   // Pull-high is on only while the pin is an input, and only in the strobe interval when strobing.
   function automatic logic pull_on(input logic [3:0] g, input logic dir, input iok_scan_type s);
      logic stb;
      stb = g[`IOK_CFG_STB] & s.display_on;
      pull_on = g[`IOK_CFG_PULL] & ~dir & (~stb | s.strobe_window);
   endfunction : pull_on

   assign idx = {2'h0, wb_adr_i[11:2]};
   assign req = wb_cyc_i & wb_stb_i & ~ack_r;
   // Writes land at the edge where the master samples ack high, while it still holds the request.
   assign wr = wb_cyc_i & wb_stb_i & ack_r & wb_we_i & wb_sel_i[0];
   assign clr = wr & (idx == `IOK_IDX_STROBE_CONTROL) & wb_dat_i[`IOK_STB_CLEAR];

   // ****************************************
   // Pad input synchronisers
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         a_s1_r <= 6'h00;
         a_s2_r <= 6'h00;
         a_s3_r <= 6'h00;
         b_s1_r <= 2'h0;
         b_s2_r <= 2'h0;
      end
      else
      begin
         a_s1_r <= port_a_in;
         a_s2_r <= a_s1_r;
         a_s3_r <= a_s2_r;
         b_s1_r <= port_b_in;
         b_s2_r <= b_s1_r;
      end
   end

   // Edge detection waits until the synchroniser chain holds real pad levels after reset.
   always_ff @(posedge clk)
   begin
      if (rst)
         settle_r <= 2'h0;
      else if (settle_r != `IOK_SYNC_SETTLE)
         settle_r <= settle_r + 2'h1;
   end

   assign timer_a_clk_in = a_s2_r[4];
   assign timer_b_clk_in = a_s2_r[5];

   // ****************************************
   // Software registers
   // ****************************************
   // reset and write
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pa_latch_r <= `IOK_RST_BYTE;
         pb_latch_r <= `IOK_RST_BYTE;
         pa_dir_r <= `IOK_RST_BYTE;
         pa_cfg_r <= `IOK_RST_BYTE;
         pb_dir_r <= `IOK_RST_BYTE;
         pb_cfg_r <= `IOK_RST_BYTE;
         pb_fsel_r <= 2'h0;
         seg_blank_r <= 1'b0;
         irq_en_r <= 1'b0;
         halt_en_r <= 1'b0;
      end
      else if (wr)
      begin
         unique case (idx)
            `IOK_IDX_PA_LATCH: pa_latch_r <= {2'h0, wb_dat_i[5:0]};
            `IOK_IDX_PB_LATCH: pb_latch_r <= {6'h00, wb_dat_i[1:0]};
            `IOK_IDX_PA_DIR: pa_dir_r <= {2'h0, wb_dat_i[5:0]};
            `IOK_IDX_PA_CFG: pa_cfg_r <= wb_dat_i[7:0];
            `IOK_IDX_PB_DIR: pb_dir_r <= {6'h00, wb_dat_i[1:0]};
            `IOK_IDX_PB_CFG: pb_cfg_r <= {4'h0, wb_dat_i[3:0]};
            `IOK_IDX_PB_FSEL: pb_fsel_r <= wb_dat_i[1:0];
            `IOK_IDX_STROBE_CONTROL: seg_blank_r <= wb_dat_i[`IOK_STB_BLANK];
            `IOK_IDX_EVENT:
            begin
               irq_en_r <= wb_dat_i[`IOK_EV_IRQ_EN];
               halt_en_r <= wb_dat_i[`IOK_EV_HALT_EN];
            end
            default:
            begin
            end
         endcase
      end
   end

   // ****************************************
   // Pad drive, six-pin port
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++)
      begin : g_pa
         logic [3:0] g;
         assign g = group_cfg(pa_cfg_r, gi);
         assign pads_a.out[gi] = pa_latch_r[gi];
         assign pads_a.oe[gi] = pa_dir_r[gi] & ~(g[`IOK_CFG_NMOS] & pa_latch_r[gi]);
         assign pads_a.pull_en[gi] = pull_on(g, pa_dir_r[gi], scan);
         assign pads_a.pull_weak[gi] = g[`IOK_CFG_WEAK];
         assign rd_a[gi] = pa_dir_r[gi] | a_s2_r[gi];
         assign hit[gi] = g[`IOK_CFG_STB] & scan.display_on & scan.strobe_window & ~pa_dir_r[gi] & ~a_s2_r[gi];
      end
   endgenerate
   assign rd_a[7:6] = 2'h0;

   // ****************************************
   // Pad drive, two-pin port
   // ****************************************
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_pb
         logic drv;
         logic val;
         assign val = pb_fsel_r[gi] ? (gi == 0 ? timer_a_carrier : timer_b_carrier) : pb_latch_r[gi];
         assign drv = pb_dir_r[gi] | pb_fsel_r[gi];
         assign pads_b.out[gi] = val;
         assign pads_b.oe[gi] = drv & ~(pb_cfg_r[`IOK_CFG_NMOS] & val);
         assign pads_b.pull_en[gi] = pull_on(pb_cfg_r[3:0], drv, scan);
         assign pads_b.pull_weak[gi] = pb_cfg_r[`IOK_CFG_WEAK];
         assign rd_b[gi] = drv | b_s2_r[gi];
         assign hit[6 + gi] = pb_cfg_r[`IOK_CFG_STB] & scan.display_on & scan.strobe_window & ~drv & ~b_s2_r[gi];
      end
   endgenerate
   assign rd_b[7:2] = 6'h00;

   // ****************************************
   // Key strobe latch
   // ****************************************
   // capture and clear
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         key_r <= `IOK_RST_BYTE;
         com_r <= `IOK_RST_COM;
         armed_r <= 1'b1;
      end
      else if (armed_r && (hit != 8'h00))
      begin
         key_r <= hit;
         com_r <= scan.common_line;
         armed_r <= 1'b0;
      end
      else if (clr && (hit != 8'h00))
      begin
         key_r <= hit;
         com_r <= scan.common_line;
         armed_r <= 1'b0;
      end
      else if (clr)
      begin
         key_r <= `IOK_RST_BYTE;
         armed_r <= 1'b1;
      end
   end

   // ****************************************
   // Pin-change event
   // ****************************************
   // edge on pins 0 and 4
   assign ev_set = (settle_r == `IOK_SYNC_SETTLE)
      & ((~pa_dir_r[0] & (a_s2_r[0] ^ a_s3_r[0])) | (~pa_dir_r[4] & (a_s2_r[4] ^ a_s3_r[4])));

   // A new edge wins over a write-one clear in the same cycle.
   always_ff @(posedge clk)
   begin
      if (rst)
         ev_r <= 1'b0;
      else if (ev_set)
         ev_r <= 1'b1;
      else if (wr && idx == `IOK_IDX_EVENT && wb_dat_i[`IOK_EV_STATUS])
         ev_r <= 1'b0;
   end

   assign port_irq = ev_r & irq_en_r;
   assign halt_release = ev_r & halt_en_r;

   // ****************************************
   // Segment blanking
   // ****************************************
   // segment blank
   always_ff @(posedge clk)
   begin
      if (rst)
         seg_r <= '0;
      else
         seg_r <= seg_blank_r ? '0 : segment_ram;
   end
   assign segment_out = seg_r;

   // ****************************************
   // Wishbone answer
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end
      else
      begin
         ack_r <= req;
         if (req && !wb_we_i)
         begin
            unique case (idx)
               `IOK_IDX_PA_LATCH: dat_r <= {24'h000000, rd_a};
               `IOK_IDX_PB_LATCH: dat_r <= {24'h000000, rd_b};
               `IOK_IDX_PA_DIR: dat_r <= {24'h000000, pa_dir_r};
               `IOK_IDX_PA_CFG: dat_r <= {24'h000000, pa_cfg_r};
               `IOK_IDX_PB_DIR: dat_r <= {24'h000000, pb_dir_r};
               `IOK_IDX_PB_CFG: dat_r <= {24'h000000, pb_cfg_r};
               `IOK_IDX_PB_FSEL: dat_r <= {30'h00000000, pb_fsel_r};
               `IOK_IDX_STROBE_COMMON_INDEX: dat_r <= {29'h00000000, com_r};
               `IOK_IDX_KEY_LATCH: dat_r <= {24'h000000, key_r};
               `IOK_IDX_EVENT: dat_r <= {29'h00000000, halt_en_r, irq_en_r, ev_r};
               default: dat_r <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) // bus
      else $error("ack held two cycles");
   AST_OUT_READS_ONE: assert property (wb_ack_o && !$past(wb_we_i) && $past(idx) == `IOK_IDX_PA_LATCH
      && $past(pa_dir_r[0]) |-> wb_dat_o[0])
      else $error("output pin did not read one");
   AST_RESET_INPUT: assert property ($past(rst) |-> pa_dir_r == 8'h00 && pb_dir_r == 8'h00)
      else $error("port not input after reset");
   AST_PULL_OFF_OUT: assert property ((pads_a.pull_en & pa_dir_r[5:0]) == 6'h00)
      else $error("pull-high on output pin");
   AST_NMOS_LOW: assert property (pa_cfg_r[`IOK_CFG_NMOS] && pads_a.oe[0] |-> !pads_a.out[0])
      else $error("open drain drove high");
   AST_EVENT_SET: assert property (settle_r == `IOK_SYNC_SETTLE && !pa_dir_r[0] && $changed(a_s2_r[0]) |=> ev_r)
      else $error("pin change did not set event");
   AST_HOLD: assert property (!armed_r && !clr |=> $stable(key_r) && $stable(com_r))
      else $error("key latch changed while held");
   AST_CLEAR: assert property (clr && hit == 8'h00 |=> key_r == 8'h00 && armed_r)
      else $error("strobe clear failed");
   AST_CAPTURE: assert property (armed_r && hit != 8'h00 |=> key_r == $past(hit)
      && com_r == $past(scan.common_line))
      else $error("strobe capture wrong");
   AST_BLANK: assert property (seg_blank_r |=> segment_out == '0)
      else $error("segments not blanked");
   AST_CARRIER: assert property (pb_fsel_r[0] && !pb_cfg_r[`IOK_CFG_NMOS] |->
      pads_b.oe[0] && pads_b.out[0] == timer_a_carrier)
      else $error("carrier not on pin");

   COV_CAPTURE: cover property (armed_r ##1 !armed_r);
   COV_EVENT_IRQ: cover property (ev_set ##1 port_irq);
   COV_CLEAR_REARM: cover property (!armed_r ##1 clr ##1 armed_r);
   COV_EVENT_HALT: cover property (ev_set ##1 halt_release);

endmodule : iok_ports

// ### sim/iok_pad_model.sv
// Keys and outside circuits on the six-pin and two-pin pads.
// Assumes a key pulls its pin low and an undriven, unpulled pin takes the outside level.
module iok_pad_model
   import iok_pkg::*;
(
   input wire iok_pad_a_type pads_a,
   input wire iok_pad_b_type pads_b,
   input wire logic [7:0] key_low,
   input wire logic [7:0] ext_level,
   output logic [5:0] port_a_in,
   output logic [1:0] port_b_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] oe;
   logic [7:0] out;
   logic [7:0] pull;

   assign oe = {pads_b.oe, pads_a.oe};
   assign out = {pads_b.out, pads_a.out};
   assign pull = {pads_b.pull_en, pads_a.pull_en};
   // The driver wins, then a pressed key, then the pull-high, then the outside level.
   assign {port_b_in, port_a_in} = (oe & out) | (~oe & ~key_low & (pull | ext_level));
endmodule : iok_pad_model

// ### sim/tb.sv
// Self-checking bench for the I/O port and key strobe block.
// Assumes the pad model on the pins and a classic Wishbone master driven from here.
`include "iok_defines.svh"

module tb
   import iok_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] RESET_IDX [10] = '{`IOK_IDX_PA_DIR, `IOK_IDX_PA_CFG, `IOK_IDX_PB_DIR, `IOK_IDX_PB_CFG,
      `IOK_IDX_PB_FSEL, `IOK_IDX_STROBE_CONTROL, `IOK_IDX_STROBE_COMMON_INDEX, `IOK_IDX_KEY_LATCH, `IOK_IDX_EVENT, 12'h100};
   logic clk, rst, cyc, stb, we, ack, car_a, car_b, clk_a, clk_b, irq, halt;
   logic [11:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, seg_ram, seg_out, got;
   logic [5:0] pa_in;
   logic [1:0] pb_in;
   logic [7:0] key_low, ext_level, dir, lat, cfg, pull;
   iok_pad_a_type pads_a;
   iok_pad_b_type pads_b;
   iok_scan_type scan;
   int failures = 0;
   int n_compared = 0;

   iok_ports dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .port_a_in(pa_in), .port_b_in(pb_in),
      .pads_a(pads_a), .pads_b(pads_b), .scan(scan), .segment_ram(seg_ram), .segment_out(seg_out),
      .timer_a_carrier(car_a), .timer_b_carrier(car_b), .timer_a_clk_in(clk_a), .timer_b_clk_in(clk_b),
      .port_irq(irq), .halt_release(halt));
   iok_pad_model model (.pads_a(pads_a), .pads_b(pads_b), .key_low(key_low), .ext_level(ext_level),
      .port_a_in(pa_in), .port_b_in(pb_in));

   initial
   begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end

   task automatic final_report;
      if (failures == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report

   task automatic check(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch at %0t: got %h, expected %h", $time, g, e);
      end
   endtask : check

   task automatic bus(input logic w, input logic [11:0] i, input logic [7:0] d);
      int n = 0;
      @(posedge clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= {i[9:0], 2'h0};
      wdat <= {24'h0, d};
      @(posedge clk);
      while (ack !== 1'h1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      got = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      if (ack !== 1'h1)
      begin
         failures++;
         $display("mismatch at %0t: no bus answer", $time);
         final_report();
      end
   endtask : bus

   task automatic wr(input logic [11:0] i, input logic [7:0] d);
      bus(1'h1, i, d);
   endtask : wr

   task automatic rd(input logic [11:0] i, input logic [31:0] e);
      bus(1'h0, i, 8'h00);
      check(got, e);
   endtask : rd

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // Output pins read as 1, input pins read their pad.
   function automatic logic [7:0] exp_port(input logic [7:0] d, input logic [7:0] lvl);
      return d | lvl;
   endfunction : exp_port

   // Spreads a group bit of the config byte over both ports, two-pin port on top.
   function automatic logic [7:0] grp(input logic [7:0] c, input int b);
      return {{2{c[b]}}, {2{c[b + 4]}}, {4{c[b]}}};
   endfunction : grp

   // ****************************************
   // Stimulus and checks
   // ****************************************
   initial
   begin
      rst = 1'h1;
      {cyc, stb, we, car_a, car_b, adr, wdat, seg_ram, key_low} = '0;
      sel = 4'hF;
      ext_level = 8'hFF;
      scan = '0;
      void'($urandom(32'hA443));
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      foreach (RESET_IDX[k]) rd(RESET_IDX[k], 32'h0);
      check({pads_b.oe, pads_a.oe}, 32'h0);
      wr(12'h100, 8'hFF);
      rd(12'h100, 32'h0);
      for (int k = 0; k < 8; k++)
      begin
         dir = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
         lat = 8'($urandom);
         cfg = (k == 1) ? 8'h77 : 8'($urandom) & 8'h77;
         ext_level <= 8'($urandom);
         wr(`IOK_IDX_PA_DIR, dir & 8'h3F);
         wr(`IOK_IDX_PA_LATCH, lat & 8'h3F);
         wr(`IOK_IDX_PA_CFG, cfg);
         wr(`IOK_IDX_PB_DIR, dir >> 6);
         wr(`IOK_IDX_PB_LATCH, lat >> 6);
         wr(`IOK_IDX_PB_CFG, cfg & 8'h07);
         pull = grp(cfg, 0) & ~dir;
         tick(4);
         check({pads_b.oe, pads_a.oe}, dir & ~(grp(cfg, 1) & lat));
         check({pads_b.out, pads_a.out} & dir, lat & dir);
         check({pads_b.pull_en, pads_a.pull_en}, pull);
         check({pads_b.pull_weak, pads_a.pull_weak} & pull, grp(cfg, 2) & pull);
         rd(`IOK_IDX_PA_DIR, dir & 8'h3F);
         rd(`IOK_IDX_PB_DIR, dir >> 6);
         rd(`IOK_IDX_PA_LATCH, exp_port(dir, ext_level | pull) & 8'h3F);
         rd(`IOK_IDX_PB_LATCH, exp_port(dir, ext_level | pull) >> 6);
      end
      wr(`IOK_IDX_PA_DIR, 8'h00);
      wr(`IOK_IDX_PA_CFG, 8'h00);
      wr(`IOK_IDX_PB_CFG, 8'h00);
      tick(5);
      wr(`IOK_IDX_EVENT, 8'h03);
      ext_level[1] <= ~ext_level[1];
      tick(5);
      check({halt, irq}, 32'h0);
      ext_level[0] <= ~ext_level[0];
      tick(5);
      check({halt, irq}, 32'h1);
      wr(`IOK_IDX_EVENT, 8'h05);
      ext_level[4] <= ~ext_level[4];
      tick(5);
      check({halt, irq}, 32'h2);
      rd(`IOK_IDX_EVENT, 32'h5);
      check({clk_b, clk_a}, ext_level[5:4]);
      wr(`IOK_IDX_PB_FSEL, 8'h03);
      for (int k = 0; k < 4; k++)
      begin
         {car_b, car_a} <= k[1:0];
         tick(2);
         check({pads_b.oe, pads_b.out}, {2'h3, k[1:0]});
      end
      rd(`IOK_IDX_PB_LATCH, 32'h3);
      wr(`IOK_IDX_PB_FSEL, 8'h00);
      for (int k = 0; k < 2; k++)
      begin
         seg_ram <= $urandom;
         wr(`IOK_IDX_STROBE_CONTROL, 8'(k));
         tick(2);
         check(seg_out, k ? 32'h0 : seg_ram);
      end
      wr(`IOK_IDX_PB_DIR, 8'h00);
      ext_level <= 8'hFF;
      wr(`IOK_IDX_PA_CFG, 8'h99);
      wr(`IOK_IDX_PB_CFG, 8'h09);
      scan <= {1'h1, 1'h0, 3'h3};
      wr(`IOK_IDX_STROBE_CONTROL, 8'h02);
      tick(2);
      check({pads_b.pull_en, pads_a.pull_en}, 32'h0);
      scan.strobe_window <= 1'h1;
      tick(2);
      check({pads_b.pull_en, pads_a.pull_en}, 32'hFF);
      key_low <= 8'h84;
      tick(5);
      scan <= {1'h1, 1'h1, 3'h1};
      key_low <= 8'h01;
      tick(5);
      rd(`IOK_IDX_KEY_LATCH, 32'h84);
      rd(`IOK_IDX_STROBE_COMMON_INDEX, 32'h3);
      key_low <= 8'h00;
      scan.strobe_window <= 1'h0;
      wr(`IOK_IDX_STROBE_CONTROL, 8'h02);
      rd(`IOK_IDX_KEY_LATCH, 32'h0);
      scan <= {1'h0, 1'h1, 3'h2};
      key_low <= 8'h02;
      tick(5);
      rd(`IOK_IDX_KEY_LATCH, 32'h0);
      scan.display_on <= 1'h1;
      tick(5);
      rd(`IOK_IDX_KEY_LATCH, 32'h2);
      rd(`IOK_IDX_STROBE_COMMON_INDEX, 32'h2);
      rd(`IOK_IDX_STROBE_CONTROL, 32'h0);
      final_report();
   end
endmodule : tb
